// >>> verilog/dcm_pkg.sv
/*
 * Package for the debug comparator match value block: register offsets,
 * reset values, control field positions and the carrier structs.
 * Assumes a byte-indexed register map on a 32-bit Avalon-MM slave.
 */
package dcm_pkg;
    // Printed offsets are byte indices; the bus byte address is four times the index.
    localparam logic [9:0] IDX_ADDR_HIGH = 10'h115;
    localparam logic [9:0] IDX_ADDR_MIDDLE = 10'h116;
    localparam logic [9:0] IDX_ADDR_LOW = 10'h117;
    localparam logic [9:0] IDX_DATA_BYTE_TOP = 10'h118;
    localparam logic [9:0] IDX_DATA_BYTE_BOTTOM = 10'h11B;
    localparam logic [9:0] IDX_MASK_BYTE_TOP = 10'h11C;
    localparam logic [9:0] IDX_MASK_BYTE_BOTTOM = 10'h11F;
    // Added control and status word for the comparator's loose bits.
    localparam logic [9:0] IDX_CONTROL = 10'h120;
    localparam logic [9:0] IDX_STATUS = 10'h121;
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_INSTRUCTION_ADDRESS_SELECT_BIT = 5;
    localparam int CTL_NDB_BIT = 6;
    localparam int STS_MATCH_BIT = 0;
    localparam int STS_ARMED_BIT = 1;
    localparam int STS_PROFILING_TRANSMISSION_ACTIVE_BIT = 2;
    localparam logic [23:0] ADDR_RESET = 24'h000000;
    localparam logic [31:0] DATA_RESET = 32'h00000000;
    localparam logic [31:0] MASK_RESET = 32'h00000000;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
    localparam int BYTE_COUNT = 4;

    // Snapshot of the observed core bus.
    typedef struct packed {
        logic [23:0] addr;
        logic [31:0] data;
    } dcm_bus_t;

    // Comparator configuration handed to the match logic.
    typedef struct packed {
        logic enable;
        logic instruction_address_select_sel;
        logic invert;
        logic [23:0] addr;
        logic [31:0] data;
        logic [31:0] mask;
    } dcm_cfg_t;
endpackage

// >>> verilog/dcm_match.sv
/*
 * Match logic for one comparator: address equality plus a masked,
 * optionally inverted data compare. Assumes inputs are on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module dcm_match (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire dcm_pkg::dcm_cfg_t cfg_in,
    input wire dcm_pkg::dcm_bus_t bus_in,
    output logic match_out
);
    logic addr_hit;
    logic data_hit;
    logic next_match;
    logic [31:0] diff_bits;

    // Each compare bit demands the level of its bus bit; mask picks the data bits.
    always_comb begin
        addr_hit = (bus_in.addr == cfg_in.addr);
        diff_bits = (bus_in.data ^ cfg_in.data) & cfg_in.mask;
        if (cfg_in.instruction_address_select_sel) begin
            data_hit = 1'b1;
        end else if (cfg_in.invert) begin
            data_hit = (diff_bits != 32'h00000000);
        end else begin
            data_hit = (diff_bits == 32'h00000000);
        end
        next_match = cfg_in.enable && addr_hit && data_hit;
    end

    // Registered so the match output is glitch free for downstream sequencing.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            match_out <= 1'b0;
        end else begin
            match_out <= next_match;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/dcm_top.sv
/*
 * Register set holding the reference values of one debug bus comparator,
 * reached over an Avalon-MM slave, plus its match output.
 * Assumes armed and profiling flags come from logic on the same clock.
 */
// Function
// - Hold 24-bit compare address as high, middle and low bytes.
// - Address bit 0 expects bus bit low, 1 expects it high.
// - Address and data bytes writable only when disarmed and profiling idle.
// - Mask bytes writable whenever disarmed, regardless of profiling.
// - Hold 32-bit data value; a bit counts only when its mask is 1.
// - Mask bit 0 excludes its data bit, 1 includes it.
// - Data value bytes at four addresses, lowest holds bits 31 to 24.
// - Mask bytes at four addresses, lowest holds most significant byte.
// - Invert control makes data match on difference of unmasked bits.
// - Data compare and its inversion ignored in instruction address mode.
`timescale 1ns/10ps
`default_nettype none
module dcm_top (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic [11:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic debug_armed_in,
    input wire logic profiling_transmission_active_in,
    input wire dcm_pkg::dcm_bus_t bus_in,
    output logic match_out
);
    logic [23:0] compare_address_field;
    logic [31:0] compare_data_value;
    logic [31:0] compare_data_mask;
    logic [7:0] control;
    logic ack;
    logic [9:0] idx;
    logic wr_go;
    logic value_open;
    logic mask_open;
    logic [31:0] next_readdata;
    logic [7:0] wr_byte;
    dcm_pkg::dcm_cfg_t cfg;
    logic data_span;
    logic mask_span;
    logic [4:0] data_hi;
    logic [4:0] mask_hi;

    assign idx = avs_address_in[11:2];
    assign wr_byte = avs_writedata_in[7:0];
    // One wait state: the request is taken on the edge where ack is high.
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;
    assign wr_go = avs_write_in && ack && avs_byteenable_in[0];
    assign value_open = !debug_armed_in && !profiling_transmission_active_in;
    assign mask_open = !debug_armed_in;

    // Byte position inside each four-index span; the lowest index holds the top byte.
    assign data_span = (idx >= dcm_pkg::IDX_DATA_BYTE_TOP)
        && (idx <= dcm_pkg::IDX_DATA_BYTE_BOTTOM);
    assign mask_span = (idx >= dcm_pkg::IDX_MASK_BYTE_TOP)
        && (idx <= dcm_pkg::IDX_MASK_BYTE_BOTTOM);
    assign data_hi = 5'h1F - {idx[1:0] - dcm_pkg::IDX_DATA_BYTE_TOP[1:0], 3'h0};
    assign mask_hi = 5'h1F - {idx[1:0] - dcm_pkg::IDX_MASK_BYTE_TOP[1:0], 3'h0};

    // Ack toggles so back-to-back requests each take two cycles.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read_in || avs_write_in) && !ack;
        end
    end

    // Address bytes; a write while locked is dropped silently but still acked.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            compare_address_field <= dcm_pkg::ADDR_RESET;
        end else if (wr_go && value_open) begin
            if (idx == dcm_pkg::IDX_ADDR_HIGH) begin
                compare_address_field[23:16] <= wr_byte;
            end
            if (idx == dcm_pkg::IDX_ADDR_MIDDLE) begin
                compare_address_field[15:8] <= wr_byte;
            end
            if (idx == dcm_pkg::IDX_ADDR_LOW) begin
                compare_address_field[7:0] <= wr_byte;
            end
        end
    end

    // Data value and mask bytes, big-endian across the four indices.
    genvar b;
    generate
        for (b = 0; b < dcm_pkg::BYTE_COUNT; b++) begin : g_byte
            localparam logic [9:0] DIDX = dcm_pkg::IDX_DATA_BYTE_TOP + 10'(b);
            localparam logic [9:0] MIDX = dcm_pkg::IDX_MASK_BYTE_TOP + 10'(b);
            localparam int HI = 31 - 8 * b;
            always_ff @(posedge mclk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    compare_data_value[HI -: 8] <= dcm_pkg::DATA_RESET[HI -: 8];
                end else if (wr_go && value_open && idx == DIDX) begin
                    compare_data_value[HI -: 8] <= wr_byte;
                end
            end
            always_ff @(posedge mclk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    compare_data_mask[HI -: 8] <= dcm_pkg::MASK_RESET[HI -: 8];
                end else if (wr_go && mask_open && idx == MIDX) begin
                    compare_data_mask[HI -: 8] <= wr_byte;
                end
            end
        end
    endgenerate

    // Comparator control follows the same lock as the value bytes.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            control <= dcm_pkg::CONTROL_RESET;
        end else if (wr_go && value_open && idx == dcm_pkg::IDX_CONTROL) begin
            control <= wr_byte;
        end
    end

    // Read mux; unmapped indices read as zero rather than erroring.
    always_comb begin
        next_readdata = dcm_pkg::UNMAPPED_READ;
        if (idx == dcm_pkg::IDX_ADDR_HIGH) begin
            next_readdata[7:0] = compare_address_field[23:16];
        end else if (idx == dcm_pkg::IDX_ADDR_MIDDLE) begin
            next_readdata[7:0] = compare_address_field[15:8];
        end else if (idx == dcm_pkg::IDX_ADDR_LOW) begin
            next_readdata[7:0] = compare_address_field[7:0];
        end else if (data_span) begin
            next_readdata[7:0] = compare_data_value[data_hi -: 8];
        end else if (mask_span) begin
            next_readdata[7:0] = compare_data_mask[mask_hi -: 8];
        end else if (idx == dcm_pkg::IDX_CONTROL) begin
            next_readdata[7:0] = control;
        end else if (idx == dcm_pkg::IDX_STATUS) begin
            next_readdata[dcm_pkg::STS_MATCH_BIT] = match_out;
            next_readdata[dcm_pkg::STS_ARMED_BIT] = debug_armed_in;
            next_readdata[dcm_pkg::STS_PROFILING_TRANSMISSION_ACTIVE_BIT] = profiling_transmission_active_in;
        end
    end

    // Read data is registered during the wait state and stands at the ack edge.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            avs_readdata_out <= 32'h00000000;
        end else if (avs_read_in && !ack) begin
            avs_readdata_out <= next_readdata;
        end
    end

    assign cfg.enable = control[dcm_pkg::CTL_ENABLE_BIT];
    assign cfg.instruction_address_select_sel = control[dcm_pkg::CTL_INSTRUCTION_ADDRESS_SELECT_BIT];
    assign cfg.invert = control[dcm_pkg::CTL_NDB_BIT];
    assign cfg.addr = compare_address_field;
    assign cfg.data = compare_data_value;
    assign cfg.mask = compare_data_mask;

    // Match logic lives in its own module to keep the bus slave readable.
    dcm_match u_match (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .cfg_in(cfg),
        .bus_in(bus_in),
        .match_out(match_out)
    );

    // Unmasked differences between the observed data and the compare value.
    logic [31:0] seen_diff;
    assign seen_diff = (bus_in.data ^ cfg.data) & cfg.mask;

    // First cycle of a request, before the slave has answered.
    sequence seq_req_start;
        (avs_read_in || avs_write_in) && !ack;
    endsequence

    // The request still held in the cycle after it started.
    sequence seq_req_held;
        seq_req_start ##1 (avs_read_in || avs_write_in);
    endsequence

    // A new request always sees a wait state first.
    chk_wait_first: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        seq_req_start |-> avs_waitrequest_out)
        else $error("No wait state on a new request.");

    // The wait state lasts one cycle, so a master never stalls longer.
    chk_wait_released: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        seq_req_held |-> !avs_waitrequest_out)
        else $error("Wait state held beyond one cycle.");

    // Read data at the answer edge carries the address high byte.
    chk_read_addr_high: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (avs_read_in && !avs_waitrequest_out && idx == dcm_pkg::IDX_ADDR_HIGH)
        |-> avs_readdata_out == {24'h000000, compare_address_field[23:16]})
        else $error("Address high byte read wrong.");

    // The highest mask index reads back the least significant mask byte.
    chk_read_mask_bottom: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (avs_read_in && !avs_waitrequest_out && idx == dcm_pkg::IDX_MASK_BYTE_BOTTOM)
        |-> avs_readdata_out == {24'h000000, compare_data_mask[7:0]})
        else $error("Mask bottom byte read wrong.");

    // Status reports the armed flag as it stood when the read was captured.
    chk_status_armed: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (avs_read_in && !ack && idx == dcm_pkg::IDX_STATUS)
        |=> avs_readdata_out[dcm_pkg::STS_ARMED_BIT] == $past(debug_armed_in))
        else $error("Status armed bit wrong.");

    // Locked address writes leave the register untouched.
    chk_addr_lock_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_go && !value_open) |=> $stable(compare_address_field))
        else $error("Address changed while locked.");

    // Mask write lands when disarmed even while profiling is active.
    chk_mask_write_open: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_go && !debug_armed_in && idx == dcm_pkg::IDX_MASK_BYTE_TOP)
        |=> compare_data_mask[31:24] == $past(wr_byte))
        else $error("Mask top byte not written.");

    // Top data index lands in bits 31 to 24.
    chk_data_top_byte: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_go && value_open && idx == dcm_pkg::IDX_DATA_BYTE_TOP)
        |=> compare_data_value[31:24] == $past(wr_byte))
        else $error("Data top byte misplaced.");

    // Bottom data index lands in bits 7 to 0.
    chk_data_bottom_byte: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_go && value_open && idx == dcm_pkg::IDX_DATA_BYTE_BOTTOM)
        |=> compare_data_value[7:0] == $past(wr_byte))
        else $error("Data bottom byte misplaced.");

    // Bottom mask index lands in bits 7 to 0.
    chk_mask_bottom_byte: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_go && mask_open && idx == dcm_pkg::IDX_MASK_BYTE_BOTTOM)
        |=> compare_data_mask[7:0] == $past(wr_byte))
        else $error("Mask bottom byte misplaced.");

    // Low address index lands in bits 7 to 0 when unlocked.
    chk_addr_low_byte: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_go && value_open && idx == dcm_pkg::IDX_ADDR_LOW)
        |=> compare_address_field[7:0] == $past(wr_byte))
        else $error("Address low byte misplaced.");

    // Locked data value writes are acknowledged but dropped.
    chk_value_lock_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_go && !value_open) |=> $stable(compare_data_value))
        else $error("Data value changed while locked.");

    // Control shares the value lock, so a live session cannot be reconfigured.
    chk_control_lock_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_go && !value_open) |=> $stable(control))
        else $error("Control changed while locked.");

    // An armed module keeps its mask whatever the profiling flag says.
    chk_mask_lock_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_go && debug_armed_in) |=> $stable(compare_data_mask))
        else $error("Mask changed while armed.");

    // A disabled comparator never matches on the next cycle.
    chk_match_enable: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !cfg.enable |=> !match_out)
        else $error("Match while disabled.");

    // Address mismatch forbids a match.
    chk_match_addr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (bus_in.addr != cfg.addr) |=> !match_out)
        else $error("Match with wrong address.");

    // Instruction mode ignores data entirely.
    chk_match_instruction_address_select: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (cfg.enable && cfg.instruction_address_select_sel && bus_in.addr == cfg.addr) |=> match_out)
        else $error("Instruction mode missed match.");

    // Inverted mode matches only on an unmasked difference.
    chk_match_invert: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (cfg.enable && !cfg.instruction_address_select_sel && cfg.invert && bus_in.addr == cfg.addr
        && seen_diff == 32'h00000000) |=> !match_out)
        else $error("Inverted compare matched on equality.");

    // Inverted mode does match once an unmasked bit differs.
    chk_match_invert_hit: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (cfg.enable && !cfg.instruction_address_select_sel && cfg.invert && bus_in.addr == cfg.addr
        && seen_diff != 32'h00000000) |=> match_out)
        else $error("Inverted compare missed a difference.");

    // Zero mask makes any data match in normal mode.
    chk_match_mask: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (cfg.enable && !cfg.invert && cfg.mask == 32'h00000000
        && bus_in.addr == cfg.addr) |=> match_out)
        else $error("Masked compare failed.");

    // Equal unmasked data matches in normal data mode.
    chk_match_equal: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (cfg.enable && !cfg.instruction_address_select_sel && !cfg.invert && bus_in.addr == cfg.addr
        && seen_diff == 32'h00000000) |=> match_out)
        else $error("Equal data did not match.");

    // A differing unmasked bit blocks a normal data match.
    chk_match_differ: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (!cfg.instruction_address_select_sel && !cfg.invert && seen_diff != 32'h00000000) |=> !match_out)
        else $error("Differing data matched.");
endmodule
`default_nettype wire

// >>> tb/dcm_top_bench.sv
/*
 * Self-checking bench for the comparator register set: reset values,
 * write locks, byte order, unmapped space and the match output.
 * Assumes the package and design files of verilog/ are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module dcm_top_bench;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [11:0] avs_address_in = 12'h000;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [3:0] avs_byteenable_in = 4'hF;
    logic [31:0] avs_writedata_in = 32'h00000000;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic debug_armed_in = 1'b0;
    logic profiling_transmission_active_in = 1'b0;
    dcm_pkg::dcm_bus_t bus_in = '0;
    logic match_out;
    logic match_look = 1'b0;
    logic [31:0] notes[$];
    logic [7:0] shadow [0:11];
    logic [31:0] seed = 32'h00000045;
    int bad_count = 0;
    int num_checks = 0;

    dcm_top dcm_top_instruction_address_select (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .debug_armed_in(debug_armed_in),
        .profiling_transmission_active_in(profiling_transmission_active_in),
        .bus_in(bus_in), .match_out(match_out));

    // The clock toggles every 50 ns, a period of 100 ns.
    initial begin
        forever #50 mclk_in = ~mclk_in;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One Avalon transfer; the request is held until waitrequest is seen low.
    task automatic bus_op(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        logic [31:0] r;
        int n;
        r = rnd();
        @(posedge mclk_in);
        avs_address_in <= {idx, 2'b00};
        avs_read_in <= ~wr;
        avs_write_in <= wr;
        avs_writedata_in <= {r[31:8], wd};
        for (n = 0; n < 20; n++) begin
            @(posedge mclk_in);
            if (avs_waitrequest_out === 1'b0) break;
        end
        if (n == 20) begin
            bad_count++;
            results();
        end
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic reg_read(input logic [9:0] idx, input logic [31:0] exp);
        notes.push_back(exp);
        bus_op(1'b0, idx, 8'h00);
    endtask

    // Mask bytes ignore the profiling flag; everything else needs both flags clear.
    task automatic reg_write(input logic [9:0] idx, input logic [7:0] wd);
        bus_op(1'b1, idx, wd);
        if (!debug_armed_in && ((idx >= 10'h11C && idx <= 10'h11F) ||
            !profiling_transmission_active_in)) begin
            shadow[idx - 10'h115] = wd;
        end
    endtask

    function automatic logic exp_match(input dcm_pkg::dcm_bus_t b);
        logic [31:0] d;
        logic [31:0] m;
        logic hit;
        d = {shadow[3], shadow[4], shadow[5], shadow[6]};
        m = {shadow[7], shadow[8], shadow[9], shadow[10]};
        hit = ((b.data ^ d) & m) == 32'h00000000;
        if (shadow[11][6]) hit = !hit;
        if (shadow[11][5]) hit = 1'b1;
        return shadow[11][0] && hit && (b.addr == {shadow[0], shadow[1], shadow[2]});
    endfunction

    // The watcher takes the oldest note whenever a read completes or a match is due.
    always @(posedge mclk_in) begin
        if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
            check("readdata", notes.pop_front(), avs_readdata_out);
        end
        if (match_look) begin
            check("match", notes.pop_front(), {31'h0, match_out});
        end
    end

    // Main sequence; each match case is checked two edges after the bus value lands.
    initial begin
        int i;
        int k;
        logic [31:0] r;
        logic [31:0] r2;
        dcm_pkg::dcm_bus_t b;
        for (i = 0; i < 12; i++) shadow[i] = 8'h00;
        repeat (3) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        for (i = 0; i < 12; i++) reg_read(10'h115 + i, 32'h00000000);
        $display("test reset values done");
        for (k = 0; k < 4; k++) begin
            debug_armed_in <= k[1];
            profiling_transmission_active_in <= k[0];
            for (i = 0; i < 11; i++) begin
                r = rnd();
                reg_write(10'h115 + i, r[7:0]);
            end
            for (i = 0; i < 11; i++) reg_read(10'h115 + i, {24'h0, shadow[i]});
            reg_read(10'h121, {29'h0, k[0], k[1], 1'b0});
        end
        $display("test write locks done");
        bus_op(1'b1, 10'h3FF, 8'hA5);
        reg_read(10'h3FF, dcm_pkg::UNMAPPED_READ);
        $display("test unmapped done");
        debug_armed_in <= 1'b0;
        profiling_transmission_active_in <= 1'b0;
        for (i = 0; i < 40; i++) begin
            r = rnd();
            r2 = rnd();
            if (i == 16) begin
                for (k = 0; k < 4; k++) reg_write(10'h11C + k, 8'h00);
            end
            reg_write(10'h120, {1'b0, r[6], r[5], 4'h0, (i % 8 != 0)});
            b.addr = {shadow[0], shadow[1], shadow[2]} ^ (r[8] ? (24'h000001 << r[12:9]) : 24'h0);
            b.data = {shadow[3], shadow[4], shadow[5], shadow[6]} ^
                (r2 & (r[13] ? ~{shadow[7], shadow[8], shadow[9], shadow[10]} : 32'hFFFFFFFF));
            bus_in <= b;
            notes.push_back({31'h0, exp_match(b)});
            @(posedge mclk_in);
            match_look <= 1'b1;
            @(posedge mclk_in);
            match_look <= 1'b0;
        end
        $display("test match done");
        results();
    end
endmodule
`default_nettype wire
